// ### core/tmrb_pkg.sv
// Purpose: constants and types shared by the timer type B register slice
// Assumes: 8-bit register port with a 4-bit byte address
// Notes: register masks clear every unimplemented bit
package tmrb_pkg;

  // ---------------------------------------------------------------------
  // bus geometry
  // ---------------------------------------------------------------------
  localparam int TMRB_ADDR_W = 4;
  localparam int TMRB_DATA_W = 8;
  localparam int TMRB_CNT_W = 16;

  // ---------------------------------------------------------------------
  // register offsets
  // ---------------------------------------------------------------------
  localparam logic [3:0] OFF_MAIN_CTRL = 4'h0;
  localparam logic [3:0] OFF_MODE_CTRL = 4'h1;
  localparam logic [3:0] OFF_EVENT_CTRL = 4'h4;
  localparam logic [3:0] OFF_INT_ENABLE = 4'h5;
  localparam logic [3:0] OFF_INT_FLAGS = 4'h6;
  localparam logic [3:0] OFF_RUN_STATUS = 4'h7;
  localparam logic [3:0] OFF_DEBUG_CTRL = 4'h8;
  localparam logic [3:0] OFF_BYTE_BUF = 4'h9;
  localparam logic [3:0] OFF_CNT_LO = 4'hA;
  localparam logic [3:0] OFF_CNT_HI = 4'hB;
  localparam logic [3:0] OFF_COMPARE_CAPTURE_VALUE_LO = 4'hC;
  localparam logic [3:0] OFF_COMPARE_CAPTURE_VALUE_HI = 4'hD;

  // ---------------------------------------------------------------------
  // reset values and writable-bit masks
  // ---------------------------------------------------------------------
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [15:0] RST_WORD = 16'h0000;
  localparam logic [7:0] MASK_MAIN = 8'h57;
  localparam logic [7:0] MASK_MODE = 8'h77;
  localparam logic [7:0] MASK_EVENT = 8'h51;
  localparam logic [7:0] MASK_BIT0 = 8'h01;

  // ---------------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------------
  localparam int MAIN_ENABLE_BIT = 0;
  localparam int MAIN_CLOCK_SOURCE_SELECT_LSB = 1;
  localparam int MAIN_CLOCK_SOURCE_SELECT_MSB = 2;
  localparam int MAIN_RESTART_FOLLOW_BIT = 4;
  localparam int MAIN_SLEEP_KEEP_BIT = 6;
  localparam int MODE_SEL_LSB = 0;
  localparam int MODE_SEL_MSB = 2;
  localparam int MODE_OUT_GATE_BIT = 4;
  localparam int MODE_OUT_START_BIT = 5;
  localparam int MODE_EVT_IMMEDIATE_BIT = 6;
  localparam int EVT_TRIGGER_EN_BIT = 0;
  localparam int EVT_EDGE_BIT = 4;
  localparam int EVT_FILTER_BIT = 6;
  localparam int FLAG_EVENT_SNAPSHOT_MODE_BIT = 0;
  localparam int STATUS_RUN_BIT = 0;
  localparam int DEBUG_KEEP_BIT = 0;

  // ---------------------------------------------------------------------
  // clock choices, filter length
  // ---------------------------------------------------------------------
  localparam logic [1:0] CLK_UNDIVIDED = 2'h0;
  localparam logic [1:0] CLK_HALVED = 2'h1;
  localparam logic [1:0] CLK_TIMER_A = 2'h2;
  localparam int FILT_SAMPLES = 4;

  typedef enum logic [2:0] {
    MODE_PERIODIC_TICK = 3'b000,
    MODE_EXPIRY_CHECK = 3'b001,
    MODE_EVENT_SNAPSHOT = 3'b010,
    MODE_FREQUENCY = 3'b011,
    MODE_PULSE_WIDTH = 3'b100,
    MODE_PERIOD_WIDTH = 3'b101,
    MODE_ONE_SHOT = 3'b110,
    MODE_EIGHT_BIT_PULSE = 3'b111
  } tmrb_mode_t;

  typedef enum logic [1:0] {
    PH_IDLE = 2'b00,
    PH_MEASURE = 2'b01,
    PH_WAIT_END = 2'b10
  } tmrb_phase_t;

endpackage

// ### core/tmrb_core.sv
// Purpose: timer type B with control registers, counter and output
// Assumes: one clock; the capture event arrives from outside that clock
// Notes: 16-bit registers use a shared byte buffer, low byte first
//
// Overview of operation
// - with sleep_keep_running set the timer runs in standby, else it halts.
// - sleep_keep_running is ignored while the timer A clock is chosen.
// - with restart_follow_timer_a set the counter restarts with timer A.
// - clock_source_select picks undivided, halved, timer A, or no clock.
// - bit 0 of main control enables the timer.
// - in one-shot mode the immediate bit raises the output on the event.
// - output_start_level gives the initial output level.
// - with output_gate clear the compare output is held at zero.
// - counting_mode_select picks one of eight counting modes.
// - the filter bit of event control enables the noise filter.
// - the filter passes a change after four equal clock samples.
// - event_trigger_input_enable lets events drive the mode action.
// - the capture flag clears on a written one or a capture read.
//
// The strobed register port was decided locally.
`timescale 1ns/10ps
module tmrb_core #(
  parameter int FILT_LEN = tmrb_pkg::FILT_SAMPLES
) (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic [tmrb_pkg::TMRB_ADDR_W-1:0] reg_addr,
  input wire logic [tmrb_pkg::TMRB_DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [tmrb_pkg::TMRB_DATA_W-1:0] reg_rdata,
  input wire logic standby_sleep,
  input wire logic debug_halt,
  input wire logic tca_count_tick,
  input wire logic tca_restart,
  input wire logic capture_event_in,
  output logic compare_capture_value_out,
  output logic event_snapshot_mode_event_out,
  output logic irq
);
  import tmrb_pkg::*;

  if (FILT_LEN < 2 || FILT_LEN > 16) begin : g_bad_filt
    $error("FILT_LEN must lie between 2 and 16");
  end

  // ---------------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------------
  logic [7:0] main_r;
  logic [7:0] mode_r;
  logic [7:0] evt_r;
  logic [7:0] ien_r;
  logic [7:0] dbg_r;
  logic [7:0] buf_r;
  logic [7:0] buf_nxt;
  logic flag_r;
  logic flag_nxt;
  logic [15:0] cnt_r;
  logic [15:0] cnt_nxt;
  logic [15:0] compare_capture_value_r;
  logic [15:0] compare_capture_value_nxt;
  logic run_r;
  logic run_nxt;
  logic out_r;
  logic out_nxt;
  logic pend_r;
  logic pend_nxt;
  logic div_r;
  logic event_snapshot_mode_set;
  tmrb_phase_t phase_r;
  tmrb_phase_t phase_nxt;
  logic [7:0] rdata_nxt;

  // ---------------------------------------------------------------------
  // address decode
  // ---------------------------------------------------------------------
  wire wr_main = reg_wr && reg_addr == OFF_MAIN_CTRL;
  wire wr_mode = reg_wr && reg_addr == OFF_MODE_CTRL;
  wire wr_evt = reg_wr && reg_addr == OFF_EVENT_CTRL;
  wire wr_ien = reg_wr && reg_addr == OFF_INT_ENABLE;
  wire wr_flags = reg_wr && reg_addr == OFF_INT_FLAGS;
  wire wr_dbg = reg_wr && reg_addr == OFF_DEBUG_CTRL;
  wire wr_buf = reg_wr && reg_addr == OFF_BYTE_BUF;
  wire wr_cnt_lo = reg_wr && reg_addr == OFF_CNT_LO;
  wire wr_cnt_hi = reg_wr && reg_addr == OFF_CNT_HI;
  wire wr_compare_capture_value_lo = reg_wr && reg_addr == OFF_COMPARE_CAPTURE_VALUE_LO;
  wire wr_compare_capture_value_hi = reg_wr && reg_addr == OFF_COMPARE_CAPTURE_VALUE_HI;
  wire rd_cnt_lo = reg_rd && reg_addr == OFF_CNT_LO;
  wire rd_compare_capture_value_lo = reg_rd && reg_addr == OFF_COMPARE_CAPTURE_VALUE_LO;

  // ---------------------------------------------------------------------
  // field views
  // ---------------------------------------------------------------------
  wire enable = main_r[MAIN_ENABLE_BIT];
  wire [1:0] clk_choice = main_r[MAIN_CLOCK_SOURCE_SELECT_MSB:MAIN_CLOCK_SOURCE_SELECT_LSB];
  wire restart_follow = main_r[MAIN_RESTART_FOLLOW_BIT];
  wire sleep_keep = main_r[MAIN_SLEEP_KEEP_BIT];
  wire [2:0] mode_bits = mode_r[MODE_SEL_MSB:MODE_SEL_LSB];
  wire tmrb_mode_t mode = tmrb_mode_t'(mode_bits);
  wire out_gate = mode_r[MODE_OUT_GATE_BIT];
  wire out_start = mode_r[MODE_OUT_START_BIT];
  wire evt_immediate = mode_r[MODE_EVT_IMMEDIATE_BIT];
  wire trig_en = evt_r[EVT_TRIGGER_EN_BIT];
  wire edge_neg = evt_r[EVT_EDGE_BIT];
  wire filt_on = evt_r[EVT_FILTER_BIT];
  wire capture_mode = mode == MODE_EVENT_SNAPSHOT ||
      mode == MODE_FREQUENCY || mode == MODE_PULSE_WIDTH ||
      mode == MODE_PERIOD_WIDTH;

  // ---------------------------------------------------------------------
  // count clock selection and halting
  // ---------------------------------------------------------------------
  wire src_tick = (clk_choice == CLK_UNDIVIDED) ? 1'b1 :
      (clk_choice == CLK_HALVED) ? div_r :
      (clk_choice == CLK_TIMER_A) ? tca_count_tick : 1'b0;
  wire sleep_halt = standby_sleep && !sleep_keep &&
      clk_choice != CLK_TIMER_A;
  wire dbg_stop = debug_halt && !dbg_r[DEBUG_KEEP_BIT];
  wire active = enable && !sleep_halt && !dbg_stop;
  wire tick = active && src_tick;
  wire follow_restart = enable && restart_follow && tca_restart;

  // ---------------------------------------------------------------------
  // event input: synchroniser and noise filter
  // ---------------------------------------------------------------------
  logic sync1_r;
  logic sync2_r;
  logic sync3_r;
  logic [FILT_LEN-1:0] hist_r;
  logic lvl_r;
  logic prev_r;
  wire all_high = &hist_r;
  wire all_low = ~|hist_r;
  wire lvl_nxt = filt_on ? (all_high ? 1'b1 : all_low ? 1'b0 : lvl_r) :
      (sync2_r == sync3_r) ? sync3_r : lvl_r;

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      sync1_r <= 1'b0;
      sync2_r <= 1'b0;
      sync3_r <= 1'b0;
      hist_r <= '0;
      lvl_r <= 1'b0;
      prev_r <= 1'b0;
    end else begin
      sync1_r <= capture_event_in;
      sync2_r <= sync1_r;
      sync3_r <= sync2_r;
      hist_r <= {hist_r[FILT_LEN-2:0], sync3_r};
      lvl_r <= lvl_nxt;
      prev_r <= lvl_r;
    end
  end

  wire ev_ok = active && trig_en;
  wire pos_edge = ev_ok && lvl_r && !prev_r;
  wire neg_edge = ev_ok && !lvl_r && prev_r;
  wire act_edge = edge_neg ? neg_edge : pos_edge;
  wire opp_edge = edge_neg ? pos_edge : neg_edge;
  wire at_top = cnt_r == compare_capture_value_r;
  wire [15:0] cnt_inc = cnt_r + 16'h0001;
  wire pwm_top = cnt_r[7:0] == compare_capture_value_r[7:0];

  // ---------------------------------------------------------------------
  // counting modes
  // ---------------------------------------------------------------------
  always_comb begin
    cnt_nxt = cnt_r;
    compare_capture_value_nxt = compare_capture_value_r;
    run_nxt = run_r;
    out_nxt = out_r;
    pend_nxt = 1'b0;
    phase_nxt = phase_r;
    event_snapshot_mode_set = 1'b0;
    if (!enable) begin
      run_nxt = 1'b0;
      out_nxt = out_start;
      phase_nxt = PH_IDLE;
    end else begin
      case (mode)
        MODE_PERIODIC_TICK: begin
          run_nxt = 1'b1;
          if (tick) begin
            cnt_nxt = at_top ? 16'h0000 : cnt_inc;
            event_snapshot_mode_set = at_top;
          end
          out_nxt = out_start;
        end
        MODE_EXPIRY_CHECK: begin
          if (act_edge) begin
            run_nxt = 1'b1;
          end else if (opp_edge) begin
            run_nxt = 1'b0;
          end
          if (run_r && tick) begin
            cnt_nxt = at_top ? 16'h0000 : cnt_inc;
            event_snapshot_mode_set = at_top;
          end
          out_nxt = out_start;
        end
        MODE_EVENT_SNAPSHOT: begin
          run_nxt = 1'b1;
          if (tick) begin
            cnt_nxt = cnt_inc;
          end
          if (act_edge) begin
            compare_capture_value_nxt = cnt_r;
            event_snapshot_mode_set = 1'b1;
          end
          out_nxt = out_start;
        end
        MODE_FREQUENCY: begin
          run_nxt = 1'b1;
          if (act_edge) begin
            compare_capture_value_nxt = cnt_r;
            cnt_nxt = 16'h0000;
            event_snapshot_mode_set = 1'b1;
          end else if (tick) begin
            cnt_nxt = cnt_inc;
          end
          out_nxt = out_start;
        end
        MODE_PULSE_WIDTH: begin
          run_nxt = 1'b1;
          if (act_edge) begin
            cnt_nxt = 16'h0000;
          end else if (tick) begin
            cnt_nxt = cnt_inc;
          end
          if (opp_edge) begin
            compare_capture_value_nxt = cnt_r;
            event_snapshot_mode_set = 1'b1;
          end
          out_nxt = out_start;
        end
        MODE_PERIOD_WIDTH: begin
          if (run_r && tick) begin
            cnt_nxt = cnt_inc;
          end
          case (phase_r)
            PH_IDLE: begin
              if (act_edge) begin
                cnt_nxt = 16'h0000;
                run_nxt = 1'b1;
                phase_nxt = PH_MEASURE;
              end
            end
            PH_MEASURE: begin
              if (opp_edge) begin
                compare_capture_value_nxt = cnt_r;
                phase_nxt = PH_WAIT_END;
              end
            end
            PH_WAIT_END: begin
              if (act_edge) begin
                run_nxt = 1'b0;
                event_snapshot_mode_set = 1'b1;
                phase_nxt = PH_IDLE;
              end
            end
            default: begin
              phase_nxt = PH_IDLE;
            end
          endcase
          out_nxt = out_start;
        end
        MODE_ONE_SHOT: begin
          if (!run_r && !pend_r && act_edge) begin
            pend_nxt = 1'b1;
            if (evt_immediate) begin
              out_nxt = 1'b1;
            end
          end
          if (pend_r) begin
            run_nxt = 1'b1;
            cnt_nxt = 16'h0000;
            out_nxt = 1'b1;
          end else if (run_r && tick) begin
            if (at_top) begin
              run_nxt = 1'b0;
              out_nxt = 1'b0;
              event_snapshot_mode_set = 1'b1;
            end else begin
              cnt_nxt = cnt_inc;
            end
          end
        end
        MODE_EIGHT_BIT_PULSE: begin
          run_nxt = 1'b1;
          if (tick) begin
            cnt_nxt = pwm_top ? 16'h0000 : {8'h00, cnt_inc[7:0]};
            event_snapshot_mode_set = pwm_top;
          end
          out_nxt = cnt_r[7:0] < compare_capture_value_r[15:8];
        end
        default: begin
          run_nxt = 1'b0;
        end
      endcase
      if (follow_restart) begin
        cnt_nxt = 16'h0000;
      end
    end
    if (wr_cnt_hi) begin
      cnt_nxt = {reg_wdata, buf_r};
    end
    if (wr_compare_capture_value_hi) begin
      compare_capture_value_nxt = {reg_wdata, buf_r};
    end
  end

  // ---------------------------------------------------------------------
  // flag, byte buffer, read mux
  // ---------------------------------------------------------------------
  wire flag_wclr = wr_flags && reg_wdata[FLAG_EVENT_SNAPSHOT_MODE_BIT];
  wire flag_rclr = rd_compare_capture_value_lo && capture_mode;
  assign flag_nxt = event_snapshot_mode_set || (flag_r && !flag_wclr && !flag_rclr);
  assign buf_nxt = rd_cnt_lo ? cnt_r[15:8] :
      rd_compare_capture_value_lo ? compare_capture_value_r[15:8] :
      (wr_buf || wr_cnt_lo || wr_compare_capture_value_lo) ? reg_wdata : buf_r;

  always_comb begin
    rdata_nxt = 8'h00;
    case (reg_addr)
      OFF_MAIN_CTRL: rdata_nxt = main_r;
      OFF_MODE_CTRL: rdata_nxt = mode_r;
      OFF_EVENT_CTRL: rdata_nxt = evt_r;
      OFF_INT_ENABLE: rdata_nxt = ien_r;
      OFF_INT_FLAGS: rdata_nxt = {7'h00, flag_r};
      OFF_RUN_STATUS: rdata_nxt = {7'h00, run_r};
      OFF_DEBUG_CTRL: rdata_nxt = dbg_r;
      OFF_BYTE_BUF: rdata_nxt = buf_r;
      OFF_CNT_LO: rdata_nxt = cnt_r[7:0];
      OFF_CNT_HI: rdata_nxt = buf_r;
      OFF_COMPARE_CAPTURE_VALUE_LO: rdata_nxt = compare_capture_value_r[7:0];
      OFF_COMPARE_CAPTURE_VALUE_HI: rdata_nxt = buf_r;
      default: rdata_nxt = 8'h00;
    endcase
  end

  // ---------------------------------------------------------------------
  // control registers
  // ---------------------------------------------------------------------
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      main_r <= RST_BYTE;
      mode_r <= RST_BYTE;
      evt_r <= RST_BYTE;
      ien_r <= RST_BYTE;
      dbg_r <= RST_BYTE;
    end else begin
      if (wr_main) main_r <= reg_wdata & MASK_MAIN;
      if (wr_mode) mode_r <= reg_wdata & MASK_MODE;
      if (wr_evt) evt_r <= reg_wdata & MASK_EVENT;
      if (wr_ien) ien_r <= reg_wdata & MASK_BIT0;
      if (wr_dbg) dbg_r <= reg_wdata & MASK_BIT0;
    end
  end

  // ---------------------------------------------------------------------
  // counter state and outputs
  // ---------------------------------------------------------------------
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      cnt_r <= RST_WORD;
      compare_capture_value_r <= RST_WORD;
      buf_r <= RST_BYTE;
      run_r <= 1'b0;
      out_r <= 1'b0;
      pend_r <= 1'b0;
      phase_r <= PH_IDLE;
      div_r <= 1'b0;
      flag_r <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      compare_capture_value_r <= compare_capture_value_nxt;
      buf_r <= buf_nxt;
      run_r <= run_nxt;
      out_r <= out_nxt;
      pend_r <= pend_nxt;
      phase_r <= phase_nxt;
      div_r <= active && !div_r;
      flag_r <= flag_nxt;
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      reg_rdata <= 8'h00;
      compare_capture_value_out <= 1'b0;
      event_snapshot_mode_event_out <= 1'b0;
      irq <= 1'b0;
    end else begin
      reg_rdata <= reg_rd ? rdata_nxt : 8'h00;
      compare_capture_value_out <= out_gate && out_nxt;
      event_snapshot_mode_event_out <= event_snapshot_mode_set;
      irq <= flag_nxt && ien_r[FLAG_EVENT_SNAPSHOT_MODE_BIT];
    end
  end

endmodule // tmrb_core

// ### test/tmrb_props.sv
// Purpose: port properties of the timer type B register slice
// Assumes: bound to tmrb_core, one clock, reset active high
// Notes: read data stands only in the cycle after the strobe
`timescale 1ns/10ps
module tmrb_props #(
  parameter int FILT_LEN = 4
) (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic [tmrb_pkg::TMRB_ADDR_W-1:0] reg_addr,
  input wire logic [tmrb_pkg::TMRB_DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [tmrb_pkg::TMRB_DATA_W-1:0] reg_rdata,
  input wire logic standby_sleep,
  input wire logic debug_halt,
  input wire logic tca_count_tick,
  input wire logic tca_restart,
  input wire logic capture_event_in,
  input wire logic compare_capture_value_out,
  input wire logic event_snapshot_mode_event_out,
  input wire logic irq
);
  import tmrb_pkg::*;
  // ---------------------------------------------------------------
  // properties
  // ---------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  a_rdata_idle: assert property (
    !reg_rd |=> reg_rdata == 8'h00) else $error("read data not idle");
  a_unmapped_zero: assert property (
    reg_rd && (reg_addr inside {4'h2, 4'h3, 4'hE, 4'hF})
    |=> reg_rdata == 8'h00) else $error("unmapped offset not zero");
  a_main_back: assert property (
    reg_wr && reg_addr == OFF_MAIN_CTRL
    ##1 reg_rd && reg_addr == OFF_MAIN_CTRL
    |=> reg_rdata == ($past(reg_wdata, 2) & MASK_MAIN))
    else $error("main control readback wrong");
  a_mode_back: assert property (
    reg_wr && reg_addr == OFF_MODE_CTRL
    ##1 reg_rd && reg_addr == OFF_MODE_CTRL
    |=> reg_rdata == ($past(reg_wdata, 2) & MASK_MODE))
    else $error("mode control readback wrong");
  a_event_back: assert property (
    reg_wr && reg_addr == OFF_EVENT_CTRL
    ##1 reg_rd && reg_addr == OFF_EVENT_CTRL
    |=> reg_rdata == ($past(reg_wdata, 2) & MASK_EVENT))
    else $error("event control readback wrong");
  a_irq_masked: assert property (
    reg_wr && reg_addr == OFF_INT_ENABLE && !reg_wdata[0]
    |-> ##2 !irq) else $error("irq high while masked");
  a_gate_low: assert property (
    reg_wr && reg_addr == OFF_MODE_CTRL && !reg_wdata[4]
    ##1 !(reg_wr && reg_addr == OFF_MODE_CTRL)
    |=> !compare_capture_value_out) else $error("output not held low by gate");
  a_start_level: assert property (
    reg_wr && reg_addr == OFF_MODE_CTRL && reg_wdata[4]
    && reg_wdata[2:0] < 3'h6 ##1 !(reg_wr && reg_addr == OFF_MODE_CTRL)
    |=> compare_capture_value_out == |($past(reg_wdata, 2) & 8'h20))
    else $error("output not at start level");
endmodule // tmrb_props

bind tmrb_core tmrb_props #(.FILT_LEN(FILT_LEN)) u_props (
  .ref_clk, .sys_rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
  .reg_rdata, .standby_sleep, .debug_halt, .tca_count_tick,
  .tca_restart, .capture_event_in, .compare_capture_value_out, .event_snapshot_mode_event_out, .irq
);

// ### test/tmrb_tca_model.sv
// Purpose: companion timer A model, count ticks and restarts
// Assumes: same clock as the timer B slice
// Notes: restart pulses only while restart_en is high
`timescale 1ns/10ps
module tmrb_tca_model #(
  parameter int TICK_DIV = 3,
  parameter int RESTART_PER = 12
) (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic restart_en,
  output logic tca_count_tick,
  output logic tca_restart
);
  logic [7:0] div_r;
  logic [7:0] per_r;
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      div_r <= 8'h00;
      per_r <= 8'h00;
    end else begin
      div_r <= (div_r == 8'(TICK_DIV - 1)) ? 8'h00 : div_r + 8'h01;
      per_r <= (per_r == 8'(RESTART_PER - 1)) ? 8'h00 : per_r + 8'h01;
    end
  end
  assign tca_count_tick = (div_r == 8'(TICK_DIV - 1));
  assign tca_restart = restart_en && (per_r == 8'(RESTART_PER - 1));
endmodule // tmrb_tca_model

// ### test/tb_top.sv
// Purpose: register-level testbench of the timer type B slice
// Assumes: timer A model ticks every 3 cycles, restarts every 12
// Notes: tick gaps are compared as ratios of the undivided gap
`timescale 1ns/10ps
module tb_top;
  import tmrb_pkg::*;
  logic ref_clk, sys_rst, reg_wr, reg_rd, standby_sleep, debug_halt;
  logic tca_count_tick, tca_restart, capture_event_in, restart_en;
  logic compare_capture_value_out, event_snapshot_mode_event_out, irq;
  logic [3:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata;
  int n_errors, comparisons, cyc, last_t, prev_t, npulse, g0, g1;
  logic [3:0] offs [6] = '{OFF_MAIN_CTRL, OFF_MODE_CTRL, OFF_EVENT_CTRL,
    OFF_INT_ENABLE, OFF_DEBUG_CTRL, 4'h2};
  logic [7:0] msks [6] = '{MASK_MAIN, MASK_MODE, MASK_EVENT, MASK_BIT0,
    MASK_BIT0, 8'h00};
  logic [7:0] ov [3] = '{8'h20, 8'h30, 8'h10};
  tmrb_core #(.FILT_LEN(4)) dut (.ref_clk, .sys_rst, .reg_addr,
    .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .standby_sleep, .debug_halt,
    .tca_count_tick, .tca_restart, .capture_event_in, .compare_capture_value_out,
    .event_snapshot_mode_event_out, .irq);
  tmrb_tca_model #(.TICK_DIV(3), .RESTART_PER(12)) u_tca (.ref_clk,
    .sys_rst, .restart_en, .tca_count_tick, .tca_restart);
  // ---------------------------------------------------------------
  // tasks
  // ---------------------------------------------------------------
  task automatic chk(input string n, input logic [15:0] e,
                     input logic [15:0] g);
    comparisons++;
    if (g !== e) begin
      n_errors++;
      $display("MISMATCH %s expected %0h seen %0h", n, e, g);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge ref_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rc(input string n, input logic [3:0] a,
                    input logic [7:0] e);
    @(posedge ref_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    @(posedge ref_clk);
    chk(n, e, reg_rdata);
  endtask
  // write then read back with no gap
  task automatic wrc(input string n, input logic [3:0] a,
                     input logic [7:0] v, input logic [7:0] e);
    wr(a, v);
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    @(posedge ref_clk);
    chk(n, e, reg_rdata);
  endtask
  // last gap between flag pulses, 0 when they stop
  task automatic gap(output int g);
    int n0;
    int k;
    n0 = npulse;
    k = 0;
    while (npulse < n0 + 3 && k < 150) begin
      wr(OFF_INT_FLAGS, 8'h01);
      k++;
    end
    g = (npulse >= n0 + 3) ? last_t - prev_t : 0;
  endtask
  task automatic run(input string n, input logic [7:0] v, input int e);
    wr(OFF_MAIN_CTRL, v);
    gap(g1);
    chk(n, e, g1);
  endtask
  // cycles from event edge to output high, 40 when none
  task automatic lat(output int l);
    l = 0;
    @(posedge ref_clk);
    capture_event_in <= 1'b1;
    while (compare_capture_value_out !== 1'b1 && l < 40) begin
      @(posedge ref_clk);
      l++;
    end
    capture_event_in <= 1'b0;
    repeat (80) @(posedge ref_clk);
  endtask
  task automatic summarize();
    $display("comparisons %0d errors %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // ---------------------------------------------------------------
  // clock, pulse monitor, watchdog
  // ---------------------------------------------------------------
  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (event_snapshot_mode_event_out === 1'b1) begin
      prev_t <= last_t;
      last_t <= cyc;
      npulse <= npulse + 1;
    end
  end
  initial begin
    #200000;
    n_errors++;
    $display("MISMATCH watchdog expected done seen timeout");
    summarize();
  end
  // ---------------------------------------------------------------
  // test sequence
  // ---------------------------------------------------------------
  initial begin
    {sys_rst, reg_wr, reg_rd, standby_sleep} = 4'hF;
    {reg_wr, reg_rd, standby_sleep, debug_halt} = 4'h0;
    {capture_event_in, restart_en} = 2'h0;
    reg_addr = 4'h0;
    reg_wdata = 8'h00;
    {n_errors, comparisons, cyc, last_t, prev_t, npulse} = '0;
    repeat (5) @(posedge ref_clk);
    sys_rst <= 1'b0;
    for (int a = 0; a < 16; a++) rc("reset", a[3:0], 8'h00);
    for (int i = 0; i < 6; i++) begin
      wrc("mask", offs[i], 8'hFF, msks[i]);
      wrc("clear", offs[i], 8'h00, 8'h00);
    end
    for (int m = 0; m < 8; m++) wrc("mode", OFF_MODE_CTRL, 8'(m), 8'(m));
    wr(OFF_CNT_LO, 8'h34);
    wr(OFF_CNT_HI, 8'h12);
    rc("count low", OFF_CNT_LO, 8'h34);
    rc("count high", OFF_CNT_HI, 8'h12);
    for (int i = 0; i < 3; i++) begin
      wr(OFF_MODE_CTRL, ov[i]);
      repeat (2) @(posedge ref_clk);
      chk("level", ov[i][4] & ov[i][5], compare_capture_value_out);
    end
    wr(OFF_COMPARE_CAPTURE_VALUE_LO, 8'h14);
    wr(OFF_COMPARE_CAPTURE_VALUE_HI, 8'h00);
    wr(OFF_CNT_LO, 8'h00);
    wr(OFF_CNT_HI, 8'h00);
    wr(OFF_INT_ENABLE, 8'h01);
    wr(OFF_MAIN_CTRL, 8'h01);
    repeat (30) @(posedge ref_clk);
    chk("irq raised", 1'b1, irq);
    rc("running", OFF_RUN_STATUS, 8'h01);
    wr(OFF_MAIN_CTRL, 8'h00);
    wr(OFF_INT_ENABLE, 8'h00);
    repeat (2) @(posedge ref_clk);
    chk("irq masked", 1'b0, irq);
    rc("flag sticky", OFF_INT_FLAGS, 8'h01);
    wr(OFF_INT_FLAGS, 8'h01);
    rc("flag cleared", OFF_INT_FLAGS, 8'h00);
    wr(OFF_INT_ENABLE, 8'h01);
    wr(OFF_MAIN_CTRL, 8'h01);
    gap(g0);
    chk("tick gap", 1'b1, g0 > 0);
    run("halved", 8'h03, 2 * g0);
    run("timer a", 8'h05, 3 * g0);
    run("reserved", 8'h07, 0);
    run("off", 8'h00, 0);
    standby_sleep <= 1'b1;
    run("standby halt", 8'h01, 0);
    run("standby run", 8'h41, g0);
    run("standby tca", 8'h05, 3 * g0);
    standby_sleep <= 1'b0;
    restart_en <= 1'b1;
    run("follow", 8'h11, 0);
    run("no follow", 8'h01, g0);
    restart_en <= 1'b0;
    wr(OFF_MODE_CTRL, 8'h07);
    run("pulse period", 8'h01, g0);
    wr(OFF_MAIN_CTRL, 8'h00);
    wr(OFF_EVENT_CTRL, 8'h01);
    wr(OFF_MODE_CTRL, 8'h16);
    wr(OFF_MAIN_CTRL, 8'h01);
    lat(g0);
    chk("sync start", 1'b1, g0 < 40);
    wr(OFF_MODE_CTRL, 8'h56);
    lat(g1);
    chk("async lead", g0 - 1, g1);
    wr(OFF_EVENT_CTRL, 8'h41);
    lat(g1);
    chk("filter delay", 1'b1, g1 >= g0 + 3 && g1 < 40);
    wr(OFF_EVENT_CTRL, 8'h00);
    lat(g1);
    chk("trigger off", 40, g1);
    wr(OFF_MAIN_CTRL, 8'h00);
    wr(OFF_CNT_LO, 8'h00);
    wr(OFF_CNT_HI, 8'h00);
    wr(OFF_MODE_CTRL, 8'h02);
    wr(OFF_EVENT_CTRL, 8'h01);
    wr(OFF_INT_FLAGS, 8'h01);
    wr(OFF_MAIN_CTRL, 8'h01);
    lat(g1);
    rc("capture flag", OFF_INT_FLAGS, 8'h01);
    // edge acted on five counts after enable
    rc("capture read", OFF_COMPARE_CAPTURE_VALUE_LO, 8'h05);
    rc("flag after read", OFF_INT_FLAGS, 8'h00);
    summarize();
  end
endmodule // tb_top
